// >>> hdl/lsu_core.sv
// Integer load/store unit: address generation, memory access, write-back.
// Assumes an in-order answering memory port behind a write-back data cache.
`timescale 1ns/1ps
`default_nettype none

module lsu_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire lsu_pkg::lsu_op_t op,
    output logic op_ready,
    input wire logic little_endian,
    output logic invalid_form,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    output logic fetch_ready,
    output logic fetch_rsp_valid,
    output logic [31:0] fetch_rsp_data,
    output logic mem_req_valid,
    output var lsu_pkg::lsu_mem_req_t mem_req,
    input wire logic mem_req_ready,
    input wire logic mem_rsp_valid,
    input wire logic [31:0] mem_rsp_data,
    output var lsu_pkg::lsu_gpr_wr_t load_wr,
    output var lsu_pkg::lsu_gpr_wr_t ea_wr
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lsu_pkg::lsu_state_t state_r, state_nxt;
    lsu_pkg::lsu_op_t op_r;
    lsu_pkg::lsu_gpr_wr_t load_wr_r, ea_wr_r;
    logic [31:0] ea_r, ea_nxt, base_eff, lo_word_r, fetch_data_r;
    logic [2:0] outst_r;
    logic invalid_r, fetch_valid_r;

    logic op_fire, req_fire, fetch_go, inv_form, split, last_req, ld_fin, swap;
    logic [1:0] off;
    logic [5:0] sh;
    logic [31:0] word_base, st_bytes, ld_bytes, ld_val, ld_ext;
    logic [63:0] st_wide, raw64, ld_sh;
    logic [7:0] st_be;

    // ------------------------------------------------------------------
    // Decode and address generation
    // ------------------------------------------------------------------
    assign op_ready = (state_r == lsu_pkg::LSU_S_IDLE) && (outst_r < lsu_pkg::LSU_OUTST_LIMIT);
    assign op_fire = op_valid && op_ready;
    assign inv_form = op.is_store && !op.is_sync
        && ((op.update && op.base_sel == lsu_pkg::LSU_GPR_ZERO) || op.record_condition_flag);

    // Base field zero reads as zero except in update forms
    assign base_eff = (op.base_sel == lsu_pkg::LSU_GPR_ZERO && !op.update) ? 32'h0 : op.base_address_register;

    always_comb begin
        unique case (op.amode)
            lsu_pkg::LSU_AM_DISP: ea_nxt = base_eff + {{16{op.disp[15]}}, op.disp};
            lsu_pkg::LSU_AM_INDEX: ea_nxt = base_eff + op.index_register;
            default: ea_nxt = base_eff;
        endcase
    end

    assign off = ea_r[1:0];
    assign sh = {1'b0, off, 3'h0};
    assign word_base = {ea_r[31:2], 2'h0};
    assign split = ({1'b0, off} + lsu_pkg::lsu_size_bytes(op_r.size)) > lsu_pkg::LSU_WORD_BYTES;
    assign swap = ~(little_endian ^ op_r.byte_rev);

    // ------------------------------------------------------------------
    // Memory request
    // ------------------------------------------------------------------
    lsu_lane_order u_st_order (
        .data_in(op_r.store_source_register),
        .size(op_r.size),
        .swap(swap),
        .data_out(st_bytes)
    );

    assign st_wide = {32'h0, st_bytes} << sh;
    assign st_be = {4'h0, lsu_pkg::lsu_size_mask(op_r.size)} << off;
    assign fetch_go = (state_r == lsu_pkg::LSU_S_IDLE) && !op_valid && fetch_valid && (outst_r == 3'h0);
    assign fetch_ready = fetch_go && mem_req_ready;
    assign req_fire = mem_req_valid && mem_req_ready;
    assign last_req = (state_r == lsu_pkg::LSU_S_ACC2) || (state_r == lsu_pkg::LSU_S_ACC1 && !split);

    always_comb begin
        mem_req_valid = 1'b0;
        mem_req = '0;
        if (state_r == lsu_pkg::LSU_S_ACC1 || state_r == lsu_pkg::LSU_S_ACC2) begin
            mem_req_valid = 1'b1;
            mem_req.coherent = op_r.coherent;
            mem_req.bypass = 1'b0;
            mem_req.write = op_r.is_store;
            if (state_r == lsu_pkg::LSU_S_ACC2) begin
                mem_req.addr = word_base + lsu_pkg::LSU_WORD_STRIDE;
                mem_req.byte_en = st_be[7:4];
                mem_req.wdata = st_wide[63:32];
            end else begin
                mem_req.addr = word_base;
                mem_req.byte_en = st_be[3:0];
                mem_req.wdata = st_wide[31:0];
            end
        end else if (fetch_go) begin
            mem_req_valid = 1'b1;
            mem_req.addr = fetch_addr;
            mem_req.byte_en = 4'hF;
            mem_req.bypass = 1'b1;
            mem_req.coherent = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            lsu_pkg::LSU_S_IDLE: begin
                if (op_fire) begin
                    if (inv_form) begin
                        state_nxt = lsu_pkg::LSU_S_IDLE;
                    end else if (op.is_sync) begin
                        state_nxt = lsu_pkg::LSU_S_DRAIN;
                    end else begin
                        state_nxt = lsu_pkg::LSU_S_ACC1;
                    end
                end else if (fetch_ready) begin
                    state_nxt = lsu_pkg::LSU_S_FWAIT;
                end
            end
            lsu_pkg::LSU_S_ACC1: begin
                if (req_fire) begin
                    if (split) begin
                        state_nxt = lsu_pkg::LSU_S_ACC2;
                    end else begin
                        state_nxt = op_r.is_store ? lsu_pkg::LSU_S_IDLE : lsu_pkg::LSU_S_LWAIT;
                    end
                end
            end
            lsu_pkg::LSU_S_ACC2: begin
                if (req_fire) begin
                    state_nxt = op_r.is_store ? lsu_pkg::LSU_S_IDLE : lsu_pkg::LSU_S_LWAIT;
                end
            end
            lsu_pkg::LSU_S_LWAIT: begin
                if (ld_fin) begin
                    state_nxt = lsu_pkg::LSU_S_IDLE;
                end
            end
            lsu_pkg::LSU_S_DRAIN: begin
                if (outst_r == 3'h0) begin
                    state_nxt = lsu_pkg::LSU_S_IDLE;
                end
            end
            lsu_pkg::LSU_S_FWAIT: begin
                if (mem_rsp_valid) begin
                    state_nxt = lsu_pkg::LSU_S_IDLE;
                end
            end
            default: state_nxt = lsu_pkg::LSU_S_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= lsu_pkg::LSU_S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_r <= '0;
            ea_r <= 32'h0;
        end else if (op_fire) begin
            op_r <= op;
            ea_r <= ea_nxt;
        end
    end

    // Stores are posted; answers come back in request order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outst_r <= 3'h0;
        end else if (req_fire && !mem_rsp_valid) begin
            outst_r <= outst_r + 3'h1;
        end else if (!req_fire && mem_rsp_valid) begin
            outst_r <= outst_r - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Load return path
    // ------------------------------------------------------------------
    assign ld_fin = (state_r == lsu_pkg::LSU_S_LWAIT) && mem_rsp_valid && (outst_r == 3'h1);
    assign raw64 = split ? {mem_rsp_data, lo_word_r} : {32'h0, mem_rsp_data};
    assign ld_sh = raw64 >> sh;

    // Low word may answer while the high word still waits to be issued
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_word_r <= 32'h0;
        end else if (mem_rsp_valid && ((state_r == lsu_pkg::LSU_S_LWAIT && outst_r == 3'h2)
            || (state_r == lsu_pkg::LSU_S_ACC2 && outst_r == 3'h1))) begin
            lo_word_r <= mem_rsp_data;
        end
    end

    assign ld_bytes = ld_sh[31:0];

    lsu_lane_order u_ld_order (
        .data_in(ld_bytes),
        .size(op_r.size),
        .swap(swap),
        .data_out(ld_val)
    );

    always_comb begin
        unique case (op_r.size)
            lsu_pkg::LSU_SZ_BYTE: ld_ext = {24'h0, ld_val[7:0]};
            lsu_pkg::LSU_SZ_HALF: ld_ext = op_r.algebraic ? {{16{ld_val[15]}}, ld_val[15:0]}
                                                          : {16'h0, ld_val[15:0]};
            default: ld_ext = ld_val;
        endcase
    end

    // ------------------------------------------------------------------
    // Register write-back and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_wr_r <= '0;
        end else begin
            load_wr_r.en <= ld_fin;
            load_wr_r.sel <= op_r.dest_sel;
            load_wr_r.data <= ld_ext;
        end
    end

    // Store address update issues with the last store request, after its data was taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ea_wr_r <= '0;
        end else begin
            ea_wr_r.en <= op_r.update && ((ld_fin && !op_r.is_store)
                || (op_r.is_store && last_req && req_fire));
            ea_wr_r.sel <= op_r.base_sel;
            ea_wr_r.data <= ea_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            invalid_r <= 1'b0;
        end else begin
            invalid_r <= op_fire && inv_form;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_valid_r <= 1'b0;
            fetch_data_r <= 32'h0;
        end else begin
            fetch_valid_r <= (state_r == lsu_pkg::LSU_S_FWAIT) && mem_rsp_valid;
            fetch_data_r <= mem_rsp_data;
        end
    end

    assign load_wr = load_wr_r;
    assign ea_wr = ea_wr_r;
    assign invalid_form = invalid_r;
    assign fetch_rsp_valid = fetch_valid_r;
    assign fetch_rsp_data = fetch_data_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_in_order_accept: assert property (op_fire && !inv_form |=> !op_ready)
        else $error("second operation accepted while one is in flight");
    chk_sync_blocks: assert property (state_r == lsu_pkg::LSU_S_DRAIN |-> !mem_req_valid && !op_ready)
        else $error("traffic during sync drain");
    chk_sync_ends: assert property (state_r == lsu_pkg::LSU_S_DRAIN && outst_r == 3'h0 |=> op_ready)
        else $error("sync did not finish after drain");
    chk_index_addr: assert property (op_fire && op.amode == lsu_pkg::LSU_AM_INDEX && op.update
        |=> ea_r == $past(op.base_address_register) + $past(op.index_register))
        else $error("indexed address wrong");
    chk_split_second: assert property (state_r == lsu_pkg::LSU_S_ACC1 && split && req_fire
        |=> mem_req_valid && mem_req.addr == $past(mem_req.addr) + lsu_pkg::LSU_WORD_STRIDE)
        else $error("misaligned access lacks second word");
    chk_load_wb: assert property (ld_fin |=> load_wr.en && load_wr.sel == op_r.dest_sel)
        else $error("load result not written one cycle after answer");
    chk_store_upd: assert property (op_r.is_store && op_r.update && last_req && req_fire
        |=> ea_wr.en && ea_wr.sel != lsu_pkg::LSU_GPR_ZERO && ea_wr.data == ea_r)
        else $error("store update write missing or wrong");
    chk_invalid_drop: assert property (op_fire && op.is_store && op.record_condition_flag
        |=> invalid_form && state_r == lsu_pkg::LSU_S_IDLE && !mem_req.write)
        else $error("invalid store form not rejected");
    chk_fetch_attr: assert property (mem_req_valid && mem_req.bypass
        |-> !mem_req.coherent && !mem_req.write && state_r == lsu_pkg::LSU_S_IDLE)
        else $error("fetch carries coherence or is not a bypass read");
    chk_sign_fill: assert property (load_wr.en && op_r.size == lsu_pkg::LSU_SZ_HALF && op_r.algebraic
        |-> load_wr.data[31:16] == {16{load_wr.data[15]}})
        else $error("algebraic half word not sign filled");
    chk_zero_fill: assert property (load_wr.en && op_r.size == lsu_pkg::LSU_SZ_BYTE
        |-> load_wr.data[31:8] == 24'h0)
        else $error("byte load not zero filled");

    cov_split_load: cover property (state_r == lsu_pkg::LSU_S_ACC2 && !op_r.is_store ##[1:20] ld_fin);
    cov_sync_wait: cover property (state_r == lsu_pkg::LSU_S_DRAIN && outst_r != 3'h0);
    cov_invalid: cover property (invalid_form);
    cov_fetch: cover property (fetch_rsp_valid);
    cov_rev_store: cover property (req_fire && op_r.byte_rev && op_r.is_store && little_endian);

endmodule // lsu_core

`default_nettype wire

// >>> hdl/lsu_lane_order.sv
// Byte-order swap of an element held in the low bytes of a word.
// Assumes byte k of the word is memory offset k; the swap is its own inverse.
`timescale 1ns/1ps
`default_nettype none

module lsu_lane_order (
    input wire logic [31:0] data_in,
    input wire lsu_pkg::lsu_size_t size,
    input wire logic swap,
    output logic [31:0] data_out
);

    always_comb begin
        data_out = data_in;
        if (swap) begin
            unique case (size)
                lsu_pkg::LSU_SZ_HALF: data_out = {data_in[31:16], data_in[7:0], data_in[15:8]};
                lsu_pkg::LSU_SZ_WORD: data_out = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
                default: data_out = data_in;
            endcase
        end
    end

endmodule // lsu_lane_order

`default_nettype wire

// >>> hdl/lsu_pkg.sv
// Types, constants and helpers for the integer load/store unit.
// Assumes a single clock domain and one memory port answering in order.
package lsu_pkg;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LSU_SZ_BYTE = 2'h0,
        LSU_SZ_HALF = 2'h1,
        LSU_SZ_WORD = 2'h2
    } lsu_size_t;

    typedef enum logic [2:0] {
        LSU_AM_DISP = 3'h1,
        LSU_AM_INDEX = 3'h2,
        LSU_AM_BASE = 3'h4
    } lsu_amode_t;

    typedef enum logic [5:0] {
        LSU_S_IDLE = 6'h01,
        LSU_S_ACC1 = 6'h02,
        LSU_S_ACC2 = 6'h04,
        LSU_S_LWAIT = 6'h08,
        LSU_S_DRAIN = 6'h10,
        LSU_S_FWAIT = 6'h20
    } lsu_state_t;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam logic [2:0] LSU_OUTST_LIMIT = 3'h6;
    localparam logic [2:0] LSU_WORD_BYTES = 3'h4;
    localparam logic [31:0] LSU_WORD_STRIDE = 32'h0000_0004;
    localparam logic [4:0] LSU_GPR_ZERO = 5'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic is_store;
        logic is_sync;
        lsu_size_t size;
        logic algebraic;
        logic update;
        logic byte_rev;
        logic record_condition_flag;
        logic coherent;
        lsu_amode_t amode;
        logic [4:0] base_sel;
        logic [4:0] dest_sel;
        logic [31:0] base_address_register;
        logic [31:0] index_register;
        logic [15:0] disp;
        logic [31:0] store_source_register;
    } lsu_op_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [3:0] byte_en;
        logic [31:0] wdata;
        logic coherent;
        logic bypass;
    } lsu_mem_req_t;

    typedef struct packed {
        logic en;
        logic [4:0] sel;
        logic [31:0] data;
    } lsu_gpr_wr_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] lsu_size_bytes(input lsu_size_t s);
        unique case (s)
            LSU_SZ_BYTE: return 3'h1;
            LSU_SZ_HALF: return 3'h2;
            default: return 3'h4;
        endcase
    endfunction

    function automatic logic [3:0] lsu_size_mask(input lsu_size_t s);
        unique case (s)
            LSU_SZ_BYTE: return 4'h1;
            LSU_SZ_HALF: return 4'h3;
            default: return 4'hF;
        endcase
    endfunction

endpackage

// >>> test/lsu_core_tb.sv
// Testbench for the load/store unit: stores, loads, invalid forms, fetch, sync.
// Assumes the memory model's start image: byte a holds a[7:0].
`timescale 1ns/1ps
`default_nettype none

module integer_load_store_unit_tb;
    logic clk, rst, op_valid, little_endian, fetch_valid, slow, op_ready, invalid_form;
    logic fetch_ready, fetch_rsp_valid, mem_req_valid, mem_req_ready, mem_rsp_valid;
    logic [31:0] fetch_addr, fetch_rsp_data, mem_rsp_data, got_ld, got_ea;
    logic ld_seen, ea_seen, inv, coh;
    logic [4:0] ea_sel;
    lsu_pkg::lsu_op_t op;
    lsu_pkg::lsu_mem_req_t mem_req;
    lsu_pkg::lsu_gpr_wr_t load_wr, ea_wr;
    logic [7:0] shadow [0:63];
    int err_total, checks, cyc, nreq, lat, lat_ref;

    lsu_core dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .op_ready(op_ready),
        .little_endian(little_endian), .invalid_form(invalid_form), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_rsp_valid(fetch_rsp_valid),
        .fetch_rsp_data(fetch_rsp_data), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
        .load_wr(load_wr), .ea_wr(ea_wr));
    lsu_mem_model mdl (.clk(clk), .rst(rst), .slow(slow), .mem_req_valid(mem_req_valid),
        .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_data(mem_rsp_data));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic lsu_pkg::lsu_op_t mk(input logic st, input lsu_pkg::lsu_size_t sz,
        input logic alg, input logic upd, input logic rev, input lsu_pkg::lsu_amode_t am,
        input logic [4:0] bs, input logic [31:0] b, input logic [31:0] ix, input logic [15:0] d,
        input logic [31:0] src);
        return '{is_store: st, is_sync: 1'b0, size: sz, algebraic: alg, update: upd, byte_rev: rev,
            record_condition_flag: 1'b0, coherent: 1'b1, amode: am, base_sel: bs, dest_sel: 5'h07,
            base_address_register: b, index_register: ix, disp: d, store_source_register: src};
    endfunction

    function automatic logic [31:0] ea_of(input lsu_pkg::lsu_op_t o);
        logic [31:0] b;
        b = (o.base_sel == 5'h00 && !o.update) ? 32'h0 : o.base_address_register;
        case (o.amode)
            lsu_pkg::LSU_AM_DISP: return b + {{16{o.disp[15]}}, o.disp};
            lsu_pkg::LSU_AM_INDEX: return b + o.index_register;
            default: return b;
        endcase
    endfunction

    function automatic int nb(input lsu_pkg::lsu_size_t s);
        return s == lsu_pkg::LSU_SZ_BYTE ? 1 : (s == lsu_pkg::LSU_SZ_HALF ? 2 : 4);
    endfunction

    // Byte k of the element sits at lane k, or mirrored when swapping
    function automatic int lane(input lsu_pkg::lsu_op_t o, input int k);
        return ~(little_endian ^ o.byte_rev) ? nb(o.size) - 1 - k : k;
    endfunction

    task automatic run_op(input lsu_pkg::lsu_op_t o);
        int n;
        n = 0;
        {ld_seen, ea_seen, inv, coh} = 4'h0;
        nreq = 0;
        op <= o;
        op_valid <= 1'b1;
        #1;
        while (op_ready !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
        @(posedge clk);
        op_valid <= 1'b0;
        n = 0;
        forever begin
            #1;
            if (load_wr.en === 1'b1) begin ld_seen = 1'b1; got_ld = load_wr.data; lat = n; end
            if (ea_wr.en === 1'b1) begin ea_seen = 1'b1; got_ea = ea_wr.data; ea_sel = ea_wr.sel; end
            if (invalid_form === 1'b1) inv = 1'b1;
            if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1) begin nreq++; coh = mem_req.coherent; end
            if ((op_ready === 1'b1 && n > 0) || n > 200) break;
            @(posedge clk);
            n++;
        end
        @(posedge clk);
    endtask

    task automatic chk_store(input lsu_pkg::lsu_op_t o, input int req);
        logic [31:0] ea;
        ea = ea_of(o);
        for (int k = 0; k < nb(o.size); k++) shadow[6'(ea + k)] = o.store_source_register[8*lane(o, k) +: 8];
        run_op(o);
        cmp(32'(nreq), 32'(req));
        cmp(32'(ea_seen), 32'(o.update));
        if (o.update) cmp(got_ea, ea);
        if (o.update) cmp(32'(ea_sel), 32'(o.base_sel));
    endtask

    task automatic chk_load(input lsu_pkg::lsu_op_t o, input logic ck);
        logic [31:0] ea;
        logic [31:0] ex;
        ea = ea_of(o);
        ex = 32'h0;
        for (int k = 0; k < nb(o.size); k++) ex[8*lane(o, k) +: 8] = shadow[6'(ea + k)];
        if (o.algebraic && ex[15]) ex[31:16] = 16'hFFFF;
        run_op(o);
        cmp(32'(ld_seen), 32'h1);
        cmp(got_ld, ex);
        cmp(32'(ea_seen), 32'(o.update));
        if (o.update) cmp(got_ea, ea);
        cmp(32'(coh), 32'(o.coherent));
        if (ck && lat_ref < 0) lat_ref = lat;
        if (ck) cmp(32'(lat), 32'(lat_ref));
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_stores();
        chk_store(mk(1'b1, lsu_pkg::LSU_SZ_WORD, 1'b0, 1'b1, 1'b0, lsu_pkg::LSU_AM_DISP, 5'h04,
            32'h24, 32'h0, 16'hFFFC, 32'hFEDCBA98), 1);
        chk_store(mk(1'b1, lsu_pkg::LSU_SZ_HALF, 1'b0, 1'b0, 1'b1, lsu_pkg::LSU_AM_INDEX, 5'h04,
            32'h28, 32'h4, 16'h0, 32'h00008123), 1);
        chk_store(mk(1'b1, lsu_pkg::LSU_SZ_BYTE, 1'b0, 1'b1, 1'b0, lsu_pkg::LSU_AM_DISP, 5'h05,
            32'h35, 32'h0, 16'h0005, 32'h35), 1);
        chk_store(mk(1'b1, lsu_pkg::LSU_SZ_WORD, 1'b0, 1'b0, 1'b0, lsu_pkg::LSU_AM_BASE, 5'h06,
            32'h1E, 32'h0, 16'h0, 32'h12345678), 2);
        chk_load(mk(1'b0, lsu_pkg::LSU_SZ_WORD, 1'b0, 1'b0, 1'b0, lsu_pkg::LSU_AM_BASE, 5'h06,
            32'h1E, 32'h0, 16'h0, 32'h0), 1'b0);
        cmp(32'(nreq), 32'h2);
    endtask

    task automatic t_invalid();
        lsu_pkg::lsu_op_t o;
        o = mk(1'b1, lsu_pkg::LSU_SZ_WORD, 1'b0, 1'b1, 1'b0, lsu_pkg::LSU_AM_DISP, 5'h00,
            32'h10, 32'h0, 16'h0, 32'h0);
        for (int i = 0; i < 2; i++) begin
            run_op(o);
            cmp({29'h0, inv, ea_seen, ld_seen}, 32'h4);
            cmp(32'(nreq), 32'h0);
            o.update = 1'b0;
            o.base_sel = 5'h04;
            o.record_condition_flag = 1'b1;
        end
    endtask

    task automatic t_loads();
        lsu_pkg::lsu_op_t tab [4];
        tab[0] = mk(1'b0, lsu_pkg::LSU_SZ_BYTE, 1'b0, 1'b0, 1'b0, lsu_pkg::LSU_AM_DISP, 5'h02,
            32'h40, 32'h0, 16'hFFFA, 32'h0);
        tab[1] = mk(1'b0, lsu_pkg::LSU_SZ_HALF, 1'b0, 1'b1, 1'b0, lsu_pkg::LSU_AM_INDEX, 5'h02,
            32'h28, 32'h4, 16'h0, 32'h0);
        tab[2] = mk(1'b0, lsu_pkg::LSU_SZ_HALF, 1'b1, 1'b1, 1'b0, lsu_pkg::LSU_AM_DISP, 5'h03,
            32'h1E, 32'h0, 16'h0004, 32'h0);
        tab[3] = mk(1'b0, lsu_pkg::LSU_SZ_WORD, 1'b0, 1'b0, 1'b1, lsu_pkg::LSU_AM_BASE, 5'h03,
            32'h20, 32'h0, 16'h0, 32'h0);
        for (int le = 0; le < 2; le++) begin
            little_endian <= le[0];
            @(posedge clk);
            for (int i = 0; i < 4; i++) chk_load(tab[i], 1'b1);
        end
        little_endian <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_fetch();
        int n;
        n = 0;
        fetch_addr <= 32'h00000020;
        fetch_valid <= 1'b1;
        #1;
        while (fetch_ready !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
        cmp({30'h0, mem_req.bypass, mem_req.coherent}, 32'h2);
        @(posedge clk);
        fetch_valid <= 1'b0;
        n = 0;
        #1;
        while (fetch_rsp_valid !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
        cmp(fetch_rsp_data, {shadow[35], shadow[34], shadow[33], shadow[32]});
        @(posedge clk);
    endtask

    task automatic t_sync();
        lsu_pkg::lsu_op_t o;
        slow <= 1'b1;
        chk_store(mk(1'b1, lsu_pkg::LSU_SZ_WORD, 1'b0, 1'b0, 1'b0, lsu_pkg::LSU_AM_BASE, 5'h04,
            32'h10, 32'h0, 16'h0, 32'hA5C3_0F96), 1);
        o = mk(1'b0, lsu_pkg::LSU_SZ_WORD, 1'b0, 1'b0, 1'b0, lsu_pkg::LSU_AM_BASE, 5'h04,
            32'h10, 32'h0, 16'h0, 32'h0);
        o.is_sync = 1'b1;
        run_op(o);
        cmp(32'(mdl.q_r.size()), 32'h0);
        o.is_sync = 1'b0;
        o.base_address_register = 32'h0E;
        chk_load(o, 1'b0);
        slow <= 1'b0;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            close_out();
        end
    end

    initial begin
        {rst, op_valid, little_endian, fetch_valid, slow} = 5'h10;
        op = '0;
        fetch_addr = 32'h0;
        lat_ref = -1;
        for (int a = 0; a < 64; a++) shadow[a] = 8'(a);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_stores();
        t_invalid();
        t_loads();
        t_fetch();
        t_sync();
        close_out();
    end
endmodule // integer_load_store_unit_tb
`default_nettype wire

// >>> test/lsu_mem_model.sv
// Memory model behind the load/store unit: one port, answers strictly in order.
// Assumes byte a of memory starts as a[7:0]; the 64 bytes wrap on the address.
`timescale 1ns/1ps
`default_nettype none

module lsu_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic mem_req_valid,
    input wire lsu_pkg::lsu_mem_req_t mem_req,
    output logic mem_req_ready,
    output logic mem_rsp_valid,
    output logic [31:0] mem_rsp_data
);
    logic [7:0] mem_r [0:63];
    logic [31:0] q_r [$];
    logic [1:0] tick_r;
    logic [3:0] wi;

    // Slow mode takes one request in four and answers every other cycle
    assign mem_req_ready = !slow || tick_r == 2'h3;
    assign wi = mem_req.addr[5:2];

    initial begin
        for (int a = 0; a < 64; a++) mem_r[a] = 8'(a);
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_r <= 2'h0;
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= 32'h0;
        end else begin
            tick_r <= tick_r + 2'h1;
            if (q_r.size() > 0 && (!slow || tick_r[0])) begin
                mem_rsp_valid <= 1'b1;
                mem_rsp_data <= q_r.pop_front();
            end else begin
                mem_rsp_valid <= 1'b0;
                // Idle data line shows the inverse of its last value
                mem_rsp_data <= ~mem_rsp_data;
            end
            if (mem_req_valid && mem_req_ready) begin
                for (int k = 0; k < 4; k++) begin
                    if (mem_req.write && mem_req.byte_en[k]) mem_r[{wi, 2'(k)}] = mem_req.wdata[8*k +: 8];
                end
                q_r.push_back(mem_req.write ? 32'h0 :
                    {mem_r[{wi, 2'h3}], mem_r[{wi, 2'h2}], mem_r[{wi, 2'h1}], mem_r[{wi, 2'h0}]});
            end
        end
    end
endmodule // lsu_mem_model
`default_nettype wire
